// ### common/wes_regs.vh
`ifndef WES_REGS_VH
`define WES_REGS_VH

// ==========================================================
// Register indices
`define WES_IDX_CONTROL        8'hC5
`define WES_IDX_EVENT_STATUS   8'hC6
`define WES_IDX_SOURCE_STATUS  8'hC7
`define WES_IDX_SOURCE_ENABLE  8'hC8

// ==========================================================
// Field positions
`define WES_BIT_ENABLE         0
`define WES_BIT_FLAG           0
`define WES_BIT_RING_TWO       1
`define WES_BIT_RING_ONE       2
`define WES_BIT_KEYBOARD       3
`define WES_BIT_MOUSE          4
`define WES_SRC_LO             1
`define WES_SRC_HI             4
`define WES_SRC_MASK           8'h1E

// ==========================================================
// Reset values
`define WES_RST_CONTROL        8'h00
`define WES_RST_EVENT_STATUS   8'h00
`define WES_RST_SOURCE_STATUS  8'h00
`define WES_RST_SOURCE_ENABLE  8'h00

`endif

// ### rtl/wes_sync.v
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for one level
module wes_sync
(
   input  wire clk,
   input  wire rst_b,
   input  wire d_in,
   output reg  q_out
);

   reg meta_reg;

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_reg <= 1'b0;
         q_out    <= 1'b0;
      end
      else
      begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// ### rtl/wes_wake_event.v
// Operation
// - Global event flag sets whenever the request would be driven, enable ignored.
// - Global event status clears only on standby-supply power-on reset.
// - Writing one to global flag clears it and releases request line.
// - Writing zero to global flag changes nothing.
// - Source status bit reads one after its event, whatever enables say.
// - Status bits: ring two bit1, ring one bit2, keyboard bit3, mouse bit4.
// - Source status clears only on standby-supply power-on reset.
// - Writing one clears a source status bit; zero does nothing.
// - Source enabled, global enabled and event: drive request line.
// - Disabled source still records status but never drives request line.
// - Enable register uses the same bit layout as status register.
// - Enable register is read/write, cleared only by standby-supply reset.
// - Control bit 0 at index C5 is global enable, default zero.
`timescale 1ns/100ps
`default_nettype none
`include "wes_regs.vh"

module wes_wake_event
(
   input  wire       clk,
   input  wire       rst_b,
   input  wire       ring_indicate_port_two,
   input  wire       ring_indicate_port_one,
   input  wire       keyboard_wake,
   input  wire       mouse_wake,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   output reg        wake_request_b
);

   // ==========================================================
   // Source inputs
   // rst_b is the standby-supply power-on reset; main-supply,
   // soft and hard resets never reach this block, so state survives them.
   // Events are active-high levels; a held level keeps re-setting status.
   wire [3:0] src_async;
   wire [3:0] src_sync;
   wire [7:0] src_event;

   assign src_async = {mouse_wake, keyboard_wake,
                       ring_indicate_port_one, ring_indicate_port_two};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_sync
         wes_sync u_sync
         (
            .clk   (clk),
            .rst_b (rst_b),
            .d_in  (src_async[gi]),
            .q_out (src_sync[gi])
         );
      end
   endgenerate

   assign src_event = {3'h0, src_sync, 1'b0};

   // ==========================================================
   // Registers
   reg        power_event_enable_reg;
   reg        power_event_flag_reg;
   reg  [7:0] source_status_reg;
   reg  [7:0] source_enable_reg;
   reg        power_event_enable_next;
   reg        power_event_flag_next;
   reg  [7:0] source_status_next;
   reg  [7:0] source_enable_next;
   reg  [7:0] rdata_next;
   reg        wake_request_b_next;
   wire       wr_ctl;
   wire       wr_evt;
   wire       wr_sst;
   wire       wr_sen;
   wire [7:0] status_after;
   wire       would_assert;

   assign wr_ctl = reg_wr && (reg_addr == `WES_IDX_CONTROL);
   assign wr_evt = reg_wr && (reg_addr == `WES_IDX_EVENT_STATUS);
   assign wr_sst = reg_wr && (reg_addr == `WES_IDX_SOURCE_STATUS);
   assign wr_sen = reg_wr && (reg_addr == `WES_IDX_SOURCE_ENABLE);

   // Set wins over a same-cycle clear so no event is lost
   assign status_after = ((source_status_reg
                          & ~(wr_sst ? reg_wdata : 8'h00))
                          | src_event) & `WES_SRC_MASK;

   // Global enable gating deliberately not applied to the flag
   assign would_assert = |(status_after & source_enable_reg);

   always @*
   begin
      power_event_enable_next = power_event_enable_reg;
      if (wr_ctl)
         power_event_enable_next = reg_wdata[`WES_BIT_ENABLE];
      source_enable_next = source_enable_reg;
      if (wr_sen)
         source_enable_next = reg_wdata & `WES_SRC_MASK;
      source_status_next = status_after;
      power_event_flag_next = power_event_flag_reg;
      if (wr_evt && reg_wdata[`WES_BIT_FLAG])
         power_event_flag_next = 1'b0;
      // New assertion condition re-sets the flag even during a clear
      if (would_assert && !(|(source_status_reg & source_enable_reg)
                            && wr_evt && reg_wdata[`WES_BIT_FLAG]))
         power_event_flag_next = 1'b1;
      if (would_assert && !power_event_flag_reg && !wr_evt)
         power_event_flag_next = 1'b1;
      wake_request_b_next = ~(power_event_enable_next
                              && power_event_flag_next
                              && would_assert);
      rdata_next = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            `WES_IDX_CONTROL:
               rdata_next = {7'h00, power_event_enable_reg};
            `WES_IDX_EVENT_STATUS:
               rdata_next = {7'h00, power_event_flag_reg};
            `WES_IDX_SOURCE_STATUS:
               rdata_next = source_status_reg;
            `WES_IDX_SOURCE_ENABLE:
               rdata_next = source_enable_reg;
            default:
               rdata_next = 8'h00;
         endcase
      end
   end

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         power_event_enable_reg <= 1'b0;
         power_event_flag_reg   <= 1'b0;
         source_status_reg      <= `WES_RST_SOURCE_STATUS;
         source_enable_reg      <= `WES_RST_SOURCE_ENABLE;
         reg_rdata              <= 8'h00;
         wake_request_b         <= 1'b1;
      end
      else
      begin
         power_event_enable_reg <= power_event_enable_next;
         power_event_flag_reg   <= power_event_flag_next;
         source_status_reg      <= source_status_next;
         source_enable_reg      <= source_enable_next;
         reg_rdata              <= rdata_next;
         wake_request_b         <= wake_request_b_next;
      end
   end

endmodule

`default_nettype wire

// ### dv/wes_wake_event_props.sv
`timescale 1ns/100ps
`default_nettype none
// =====
// Wake event port checks
module wes_wake_event_props
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       wake_request_b
);
   logic       en_q;
   logic [7:0] se_q;
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Shadows of host writes, so gating can be judged from ports alone
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         en_q <= 1'b0;
         se_q <= 8'h00;
      end
      else if (reg_wr && reg_addr == 8'hC5)
         en_q <= reg_wdata[0];
      else if (reg_wr && reg_addr == 8'hC8)
         se_q <= reg_wdata & 8'h1E;
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("rdata outside slot");
   AST_UNMAPPED: assert property ($past(reg_rd) && ($past(reg_addr) < 8'hC5
      || $past(reg_addr) > 8'hC8) |-> reg_rdata == 8'h00) else $error("unmapped read");
   AST_CTRL_RB: assert property ($past(reg_rd) && $past(reg_addr) == 8'hC5
      |-> reg_rdata == {7'h00, $past(en_q)}) else $error("control readback");
   AST_SRC_EN_RB: assert property ($past(reg_rd) && $past(reg_addr) == 8'hC8
      |-> reg_rdata == $past(se_q)) else $error("enable readback");
   AST_STS_RSVD: assert property ($past(reg_rd) && $past(reg_addr) == 8'hC7
      |-> (reg_rdata & 8'hE1) == 8'h00) else $error("status reserved bits");
   AST_GATE_OFF: assert property (!en_q && !$past(en_q) |-> wake_request_b)
      else $error("line low while gated");
   AST_CAUSE: assert property ($fell(wake_request_b) |-> en_q && se_q != 8'h00)
      else $error("line low without cause");
   AST_W1C: assert property (reg_wr && reg_addr == 8'hC6 && reg_wdata[0]
      |-> ##[1:2] wake_request_b) else $error("line kept after clear");
   C_WAKE: cover property ($fell(wake_request_b));
   C_CLR: cover property (reg_wr && reg_addr == 8'hC7);
   C_RD: cover property ($past(reg_rd) && reg_rdata != 8'h00);
endmodule
bind wes_wake_event wes_wake_event_props u_wes_wake_event_props (.clk, .rst_b, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wake_request_b);
`default_nettype wire

// ### dv/wes_host_pme.sv
`timescale 1ns/100ps
`default_nettype none
// =====
// Host event input, counts requests
module wes_host_pme
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       wake_request_b,
   output var  logic [7:0] wake_count
);
   logic line_q;
   // Level line: a held request counts once
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         line_q     <= 1'b1;
         wake_count <= 8'h00;
      end
      else
      begin
         line_q <= wake_request_b;
         if (line_q && !wake_request_b)
            wake_count <= wake_count + 8'h01;
      end
endmodule
`default_nettype wire

// ### dv/wes_wake_event_tb.sv
`timescale 1ns/100ps
`default_nettype none
module wes_wake_event_tb;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [3:0] ev = 4'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       wake_request_b;
   logic [7:0] wake_count;
   int         mismatches = 0;
   int         tests_run = 0;
   always #10 clk = ~clk;
   wes_wake_event u_wes_wake_event (.clk, .rst_b, .ring_indicate_port_two(ev[0]),
      .ring_indicate_port_one(ev[1]), .keyboard_wake(ev[2]), .mouse_wake(ev[3]),
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wake_request_b);
   wes_host_pme u_wes_host_pme (.clk, .rst_b, .wake_request_b, .wake_count);
   // =====
   // Access and compare tasks
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic line(input logic e);
      // Step off the edge so the registered line has settled
      #1;
      chk("line", {7'h00, e}, {7'h00, wake_request_b});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("rdata", e, reg_rdata);
   endtask
   // Held past the synchroniser so a source cannot be missed
   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      repeat (4) @(posedge clk);
      ev[i] <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (2000) @(posedge clk);
      mismatches++;
      give_verdict;
   end
   // =====
   // Tests
   initial
   begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      for (int a = 8'hC4; a <= 8'hC8; a++)
         rd(8'(a), 8'h00);
      wr(8'hC4, 8'hFF);
      rd(8'hC4, 8'h00);
      wr(8'hC8, 8'hFF);
      rd(8'hC8, 8'h1E);
      wr(8'hC5, 8'hFF);
      rd(8'hC5, 8'h01);
      pulse(2);
      line(1'b0);
      rd(8'hC7, 8'h08);
      rd(8'hC6, 8'h01);
      wr(8'hC6, 8'h00);
      rd(8'hC6, 8'h01);
      line(1'b0);
      // Clearing the flag while the enabled source is still pending re-arms it
      wr(8'hC6, 8'h01);
      rd(8'hC6, 8'h01);
      line(1'b0);
      wr(8'hC7, 8'h08);
      wr(8'hC6, 8'h01);
      repeat (2) @(posedge clk);
      line(1'b1);
      rd(8'hC6, 8'h00);
      rd(8'hC7, 8'h00);
      chk("count", 8'h02, wake_count);
      wr(8'hC8, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         pulse(i);
         line(1'b1);
         rd(8'hC7, 8'(2 << i));
         wr(8'hC7, 8'hFF);
      end
      rd(8'hC6, 8'h00);
      wr(8'hC5, 8'h00);
      wr(8'hC8, 8'h10);
      pulse(3);
      line(1'b1);
      rd(8'hC6, 8'h01);
      wr(8'hC7, 8'hFF);
      wr(8'hC6, 8'hFF);
      rd(8'hC6, 8'h00);
      give_verdict;
   end
endmodule
`default_nettype wire
